// ===== src/tps_reg_bank.sv
// Byte-wide register bank of the thermopile sensor: measurement readback,
// control fields, event latch and interrupt pin, auto-incrementing pointer.
// Assumes the serial slave front end and the processing core share i_mclk.
//
// Functional notes
// - 17-bit raw object value in bytes 1, 2 and bit 7 of byte 3.
// - 15-bit raw ambient value in byte 3 bits 6:0 and byte 4.
// - Two 20-bit filtered object values packed into bytes 5 to 9.
// - 16-bit filtered ambient value in bytes 10 and 11.
// - Motion hit copies second filtered value, scaled, into bytes 12-14.
// - Byte 15 is presence magnitude; its sign lives in the status byte.
// - Control values undefined at power-up; host must initialise them all (the bank clears them all to zero on i_arst_n).
// - Byte 26: cycle time 1:0, source 3:2, overtemp direction 4.
// - Reading the event latch clears it and releases the interrupt pin.
// - Interrupt pin condition is event latch flags gated by the mask byte.
// - Pointer increments after every byte and wraps past 63 to 0.
// - Writes to non-writable registers leave contents unchanged.
`timescale 1ns/10ps
`default_nettype none

module tps_reg_bank
	import tps_reg_pkg::*;
(
	// Clock and reset
	input  wire logic                   i_mclk,
	input  wire logic                   i_arst_n,
	// Byte port from the serial front end
	input  wire logic                   i_ptr_load,
	input  wire logic [7:0]             i_ptr_addr,
	input  wire logic                   i_wr,
	input  wire logic [7:0]             i_wdata,
	input  wire logic                   i_rd,
	output logic      [7:0]             o_rdata,
	output logic                        o_rvalid,
	// Processing core
	input  wire tps_meas_type           i_meas,
	input  wire logic                   i_motion_hit,
	input  wire logic [NVM_BYTES*8-1:0] i_nvm_image,
	input  wire logic [7:0]             i_bus_address,
	output tps_ctrl_type                o_ctrl,
	// Interrupt pin, low while an unmasked event is pending
	output logic                        o_int_n
);

	logic [ADDR_W-1:0] ptr_q;
	logic [7:0]        rdata_q;
	logic              rvalid_q;
	tps_ctrl_type      ctrl_q;
	logic [23:0]       held_q;
	logic [7:0]        latch_q;
	logic [7:0]        latch_d;
	logic              int_n_q;
	logic              take_wr;
	logic              take_rd;
	logic [7:0]        rd_byte;
	logic [7:0]        ev_set;

	// A pointer load owns its cycle; a write beats a read in the same cycle
	assign take_wr = i_wr && !i_ptr_load;
	assign take_rd = i_rd && !i_ptr_load && !i_wr;

	// The pointer wraps at the map's end only if it is exactly six bits,
	// and the image must fill the span between its first and last offsets
	if (ADDR_W != 6) begin : g_ptr_check
		$error("pointer width must be six bits");
	end
	if (NVM_BYTES != OFS_NVM_LAST - OFS_NVM_FIRST + 1) begin : g_nvm_check
		$error("image size does not match its address span");
	end

	// Address pointer
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ptr_q <= '0;
		end else if (i_ptr_load) begin
			ptr_q <= i_ptr_addr[ADDR_W-1:0];
		end else if (take_wr || take_rd) begin
			ptr_q <= ptr_q + 1'b1;
		end
	end

	// Control fields; cleared at reset only so the logic starts defined
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_q.filter_a_select       <= RST_NIBBLE;
			ctrl_q.filter_b_select       <= RST_NIBBLE;
			ctrl_q.filter_c_select       <= RST_NIBBLE;
			ctrl_q.presence_limit        <= RST_BYTE;
			ctrl_q.motion_limit          <= RST_BYTE;
			ctrl_q.ambient_jump_limit    <= RST_BYTE;
			ctrl_q.event_mask            <= '0;
			ctrl_q.motion_cycle          <= '0;
			ctrl_q.presence_source       <= '0;
			ctrl_q.overtemp_dir          <= 1'b0;
			ctrl_q.periodic_event_period <= RST_BYTE;
			ctrl_q.overtemp_limit        <= '0;
			ctrl_q.nvm_access_control    <= RST_BYTE;
		end else if (take_wr) begin
			case (ptr_q)
				OFS_FILTER_A_B_SELECT: begin
					ctrl_q.filter_a_select <= i_wdata[3:0];
					ctrl_q.filter_b_select <= i_wdata[7:4];
				end
				OFS_FILTER_C_SELECT: begin
					ctrl_q.filter_c_select <= i_wdata[3:0];
				end
				OFS_PRESENCE_LIMIT: begin
					ctrl_q.presence_limit <= i_wdata;
				end
				OFS_MOTION_LIMIT: begin
					ctrl_q.motion_limit <= i_wdata;
				end
				OFS_AMB_JUMP_LIMIT: begin
					ctrl_q.ambient_jump_limit <= i_wdata;
				end
				OFS_EVENT_MASK: begin
					ctrl_q.event_mask <= i_wdata[EV_FLAG_W-1:0];
				end
				OFS_DETECT_CONFIG: begin
					ctrl_q.motion_cycle    <= i_wdata[DCFG_CYCLE_LSB +: 2];
					ctrl_q.presence_source <= i_wdata[DCFG_SOURCE_LSB +: 2];
					ctrl_q.overtemp_dir    <= i_wdata[DCFG_OT_DIR_BIT];
				end
				OFS_PERIODIC_PERIOD: begin
					ctrl_q.periodic_event_period <= i_wdata;
				end
				OFS_OVERTEMP_HIGH: begin
					ctrl_q.overtemp_limit[15:8] <= i_wdata;
				end
				OFS_OVERTEMP_LOW: begin
					ctrl_q.overtemp_limit[7:0] <= i_wdata;
				end
				OFS_NVM_CONTROL: begin
					ctrl_q.nvm_access_control <= i_wdata;
				end
				default: begin
					// Read-only and reserved bytes keep their content
					ctrl_q <= ctrl_q;
				end
			endcase
		end
	end

	// Held copy of the second filter value, taken on a motion hit
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			held_q <= '0;
		end else if (i_motion_hit) begin
			held_q <= {i_meas.object_filter_b, {HELD_SHIFT{1'b0}}};
		end
	end

	// Event latch: live flags and their signs stick until read
	always_comb begin
		ev_set = '0;
		ev_set[EV_FLAG_W-1:0] = i_meas.live_condition[EV_FLAG_W-1:0];
		for (int i = 0; i < 3; i++) begin
			ev_set[EV_SIGN_LSB+i] = i_meas.live_condition[EV_JUMP_FLAG+i]
				&& i_meas.live_condition[EV_SIGN_LSB+i];
		end
		// A new event in the clearing cycle survives the clear
		if (take_rd && ptr_q == OFS_EVENT_LATCH) begin
			latch_d = ev_set;
		end else begin
			latch_d = latch_q | ev_set;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			latch_q <= '0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// Pin follows the latched flags under the mask; high when released
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			int_n_q <= 1'b1;
		end else begin
			int_n_q <= ~|(latch_d[EV_FLAG_W-1:0] & ctrl_q.event_mask);
		end
	end

	// Read multiplexer
	always_comb begin
		rd_byte = 8'h00;
		case (ptr_q)
			OFS_OBJECT_RAW_HIGH:   rd_byte = i_meas.object_raw[16:9];
			OFS_OBJECT_RAW_MID:    rd_byte = i_meas.object_raw[8:1];
			OFS_OBJ_LSB_AMB_HIGH:  rd_byte = {i_meas.object_raw[0],
				i_meas.ambient_raw[14:8]};
			OFS_AMBIENT_RAW_LOW:   rd_byte = i_meas.ambient_raw[7:0];
			OFS_FILTER_A_HIGH:     rd_byte = i_meas.object_filter_a[19:12];
			OFS_FILTER_A_MID:      rd_byte = i_meas.object_filter_a[11:4];
			OFS_FILTER_A_B_SHARED: rd_byte = {i_meas.object_filter_a[3:0],
				i_meas.object_filter_b[19:16]};
			OFS_FILTER_B_MID:      rd_byte = i_meas.object_filter_b[15:8];
			OFS_FILTER_B_LOW:      rd_byte = i_meas.object_filter_b[7:0];
			OFS_AMB_FILTER_HIGH:   rd_byte = i_meas.ambient_filter[15:8];
			OFS_AMB_FILTER_LOW:    rd_byte = i_meas.ambient_filter[7:0];
			OFS_HELD_HIGH:         rd_byte = held_q[23:16];
			OFS_HELD_MID:          rd_byte = held_q[15:8];
			OFS_HELD_LOW:          rd_byte = held_q[7:0];
			OFS_PRESENCE_MAG:      rd_byte = i_meas.presence_delta;
			OFS_MOTION_MAG:        rd_byte = i_meas.motion_delta;
			OFS_AMB_JUMP_MAG:      rd_byte = i_meas.ambient_jump;
			OFS_EVENT_LATCH:       rd_byte = latch_q;
			OFS_LIVE_CONDITION:    rd_byte = i_meas.live_condition;
			OFS_FILTER_A_B_SELECT: rd_byte = {ctrl_q.filter_b_select,
				ctrl_q.filter_a_select};
			OFS_FILTER_C_SELECT:   rd_byte = {4'h0,
				ctrl_q.filter_c_select};
			OFS_PRESENCE_LIMIT:    rd_byte = ctrl_q.presence_limit;
			OFS_MOTION_LIMIT:      rd_byte = ctrl_q.motion_limit;
			OFS_AMB_JUMP_LIMIT:    rd_byte = ctrl_q.ambient_jump_limit;
			OFS_EVENT_MASK:        rd_byte = {3'h0, ctrl_q.event_mask};
			OFS_DETECT_CONFIG:     rd_byte = {3'h0, ctrl_q.overtemp_dir,
				ctrl_q.presence_source, ctrl_q.motion_cycle};
			OFS_PERIODIC_PERIOD:   rd_byte = ctrl_q.periodic_event_period;
			OFS_OVERTEMP_HIGH:     rd_byte = ctrl_q.overtemp_limit[15:8];
			OFS_OVERTEMP_LOW:      rd_byte = ctrl_q.overtemp_limit[7:0];
			OFS_NVM_CONTROL:       rd_byte = ctrl_q.nvm_access_control;
			OFS_BUS_ADDRESS:       rd_byte = i_bus_address;
			default: begin
				if (ptr_q >= OFS_NVM_FIRST && ptr_q <= OFS_NVM_LAST) begin
					rd_byte = i_nvm_image[8*(ptr_q - OFS_NVM_FIRST) +: 8];
				end else begin
					rd_byte = 8'h00;
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= take_rd;
			if (take_rd) begin
				rdata_q <= rd_byte;
			end
		end
	end

	assign o_rdata  = rdata_q;
	assign o_rvalid = rvalid_q;
	assign o_ctrl   = ctrl_q;
	assign o_int_n  = int_n_q;

endmodule

`default_nettype wire

// ===== src/tps_reg_pkg.sv
// Register map, field layout and carrier types of the sensor register bank.
// Assumes a byte-wide register port driven by the serial slave front end.
package tps_reg_pkg;

	localparam int ADDR_W    = 6;
	localparam int NVM_BYTES = 31;

	// Register offsets
	localparam logic [5:0] OFS_RESERVED_ZERO      = 6'h00;
	localparam logic [5:0] OFS_OBJECT_RAW_HIGH    = 6'h01;
	localparam logic [5:0] OFS_OBJECT_RAW_MID     = 6'h02;
	localparam logic [5:0] OFS_OBJ_LSB_AMB_HIGH   = 6'h03;
	localparam logic [5:0] OFS_AMBIENT_RAW_LOW    = 6'h04;
	localparam logic [5:0] OFS_FILTER_A_HIGH      = 6'h05;
	localparam logic [5:0] OFS_FILTER_A_MID       = 6'h06;
	localparam logic [5:0] OFS_FILTER_A_B_SHARED  = 6'h07;
	localparam logic [5:0] OFS_FILTER_B_MID       = 6'h08;
	localparam logic [5:0] OFS_FILTER_B_LOW       = 6'h09;
	localparam logic [5:0] OFS_AMB_FILTER_HIGH    = 6'h0a;
	localparam logic [5:0] OFS_AMB_FILTER_LOW     = 6'h0b;
	localparam logic [5:0] OFS_HELD_HIGH          = 6'h0c;
	localparam logic [5:0] OFS_HELD_MID           = 6'h0d;
	localparam logic [5:0] OFS_HELD_LOW           = 6'h0e;
	localparam logic [5:0] OFS_PRESENCE_MAG       = 6'h0f;
	localparam logic [5:0] OFS_MOTION_MAG         = 6'h10;
	localparam logic [5:0] OFS_AMB_JUMP_MAG       = 6'h11;
	localparam logic [5:0] OFS_EVENT_LATCH        = 6'h12;
	localparam logic [5:0] OFS_LIVE_CONDITION     = 6'h13;
	localparam logic [5:0] OFS_FILTER_A_B_SELECT  = 6'h14;
	localparam logic [5:0] OFS_FILTER_C_SELECT    = 6'h15;
	localparam logic [5:0] OFS_PRESENCE_LIMIT     = 6'h16;
	localparam logic [5:0] OFS_MOTION_LIMIT       = 6'h17;
	localparam logic [5:0] OFS_AMB_JUMP_LIMIT     = 6'h18;
	localparam logic [5:0] OFS_EVENT_MASK         = 6'h19;
	localparam logic [5:0] OFS_DETECT_CONFIG      = 6'h1a;
	localparam logic [5:0] OFS_PERIODIC_PERIOD    = 6'h1b;
	localparam logic [5:0] OFS_OVERTEMP_HIGH      = 6'h1c;
	localparam logic [5:0] OFS_OVERTEMP_LOW       = 6'h1d;
	localparam logic [5:0] OFS_RESERVED_SPARE     = 6'h1e;
	localparam logic [5:0] OFS_NVM_CONTROL        = 6'h1f;
	localparam logic [5:0] OFS_NVM_FIRST          = 6'h20;
	localparam logic [5:0] OFS_NVM_LAST           = 6'h3e;
	localparam logic [5:0] OFS_BUS_ADDRESS        = 6'h3f;

	// Field positions in the detect configuration byte
	localparam int DCFG_CYCLE_LSB  = 0;
	localparam int DCFG_SOURCE_LSB = 2;
	localparam int DCFG_OT_DIR_BIT = 4;
	// Event bit positions (status and latch share the layout)
	localparam int EV_FLAG_W       = 5;
	localparam int EV_SIGN_LSB     = 5;
	localparam int EV_JUMP_FLAG    = 1;
	// Held copy is the second filter value shifted up by this many bits
	localparam int HELD_SHIFT      = 4;

	// Reset values of the control state
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [3:0] RST_NIBBLE = 4'h0;

	typedef struct packed {
		logic [16:0] object_raw;
		logic [14:0] ambient_raw;
		logic [19:0] object_filter_a;
		logic [19:0] object_filter_b;
		logic [15:0] ambient_filter;
		logic [7:0]  presence_delta;
		logic [7:0]  motion_delta;
		logic [7:0]  ambient_jump;
		logic [7:0]  live_condition;
	} tps_meas_type;

	typedef struct packed {
		logic [3:0]  filter_a_select;
		logic [3:0]  filter_b_select;
		logic [3:0]  filter_c_select;
		logic [7:0]  presence_limit;
		logic [7:0]  motion_limit;
		logic [7:0]  ambient_jump_limit;
		logic [4:0]  event_mask;
		logic [1:0]  motion_cycle;
		logic [1:0]  presence_source;
		logic        overtemp_dir;
		logic [7:0]  periodic_event_period;
		logic [15:0] overtemp_limit;
		logic [7:0]  nvm_access_control;
	} tps_ctrl_type;

endpackage

// ===== sim/tps_reg_bank_asserts.sv
// Port checks of the register bank: read answer, pointer, write guard, pin.
// Bound to every bank instance; sees only the bank's ports.
`timescale 1ns/10ps
`default_nettype none
module tps_reg_bank_chk
	import tps_reg_pkg::*;
(
	// Clock and reset
	input wire logic         i_mclk,
	input wire logic         i_arst_n,
	// Byte port, measurements and outputs
	input wire logic         i_ptr_load,
	input wire logic [7:0]   i_ptr_addr,
	input wire logic         i_wr,
	input wire logic [7:0]   i_wdata,
	input wire logic         i_rd,
	input wire logic [7:0]   o_rdata,
	input wire logic         o_rvalid,
	input wire tps_meas_type i_meas,
	input wire tps_ctrl_type o_ctrl,
	input wire logic         o_int_n
);
	wire logic [5:0] pa   = i_ptr_addr[5:0];
	wire logic       ld   = i_ptr_load;
	wire logic       rd_t = i_rd && !i_wr && !i_ptr_load;
	wire logic       wr_t = i_wr && !i_ptr_load;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	a_read_answer: assert property (rd_t |=> o_rvalid)
		else $error("read not answered");
	a_object_high: assert property (ld && pa == 6'h01 ##1 rd_t
		|=> o_rdata == $past(i_meas.object_raw[16:9]))
		else $error("object high byte wrong");
	a_addr_wrap: assert property (ld && pa == 6'h3f ##1 rd_t ##1 rd_t
		|=> o_rdata == 8'h00) else $error("pointer did not wrap");
	a_config_write: assert property (ld && pa == 6'h1a ##1 wr_t |=>
		o_ctrl.presence_source == $past(i_wdata[3:2])
		&& o_ctrl.overtemp_dir == $past(i_wdata[4])) else $error("config");
	a_status_ro: assert property (ld && pa == 6'h13 ##1 wr_t
		|=> $stable(o_ctrl)) else $error("read-only write took effect");
	a_int_raise: assert property (
		|(i_meas.live_condition[4:0] & o_ctrl.event_mask) |=> !o_int_n)
		else $error("unmasked event left pin high");
	a_int_masked: assert property (!o_int_n
		|-> |(o_ctrl.event_mask | $past(o_ctrl.event_mask)))
		else $error("pin low with mask clear");
	a_read_clears: assert property (ld && pa == 6'h12 ##1
		(rd_t && i_meas.live_condition[4:0] == 5'h00) |=> o_int_n)
		else $error("latch read did not release pin");
endmodule
bind tps_reg_bank tps_reg_bank_chk u_chk (.i_mclk, .i_arst_n, .i_ptr_load,
	.i_ptr_addr, .i_wr, .i_wdata, .i_rd, .o_rdata, .o_rvalid, .i_meas,
	.o_ctrl, .o_int_n);
`default_nettype wire

// ===== sim/tps_host_model.sv
// Serial front end stand-in: one byte-port request per clock.
// Requests change at the falling edge and hold across one rising edge.
`timescale 1ns/10ps
`default_nettype none
module tps_host_model (
	// Clock
	input  wire logic       i_mclk,
	// Byte port toward the bank
	output var  logic       o_ptr_load,
	output var  logic [7:0] o_ptr_addr,
	output var  logic       o_wr,
	output var  logic [7:0] o_wdata,
	output var  logic       o_rd,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid
);
	initial {o_ptr_load, o_wr, o_rd, o_ptr_addr, o_wdata} = '0;
	// k is {load, write, read}; the previous answer is sampled first
	task automatic op(input logic [2:0] k, input logic [7:0] d,
		output logic v, output logic [7:0] q);
		@(negedge i_mclk);
		v = i_rvalid;
		q = i_rdata;
		{o_ptr_load, o_wr, o_rd} = k;
		// Unused lines toggle so a stale value is never mistaken for data
		o_ptr_addr = k[2] ? d : ~o_ptr_addr;
		o_wdata = k[1] ? d : ~o_wdata;
		@(posedge i_mclk);
	endtask
endmodule
`default_nettype wire

// ===== sim/thermopile_sensor_register_map_tb_top.sv
// Directed test of the register bank through the host request model.
// Needs the package, bank, checker and host model compiled before it.
`timescale 1ns/10ps
`default_nettype none
module thermopile_sensor_register_map_tb_top
	import tps_reg_pkg::*;
;
	logic         mclk = 1'b0;
	logic         arst_n = 1'b0;
	logic         hit = 1'b0;
	logic         ld, wr, rd, rv, int_n, v;
	logic [7:0]   pa, wd, rdat, q;
	logic [7:0]   wb [12], rb [12];
	logic [135:0] ex;
	logic [31:0]  wrp;
	// Top image byte differs so a reversed byte order shows up
	logic [247:0] nvm = {8'hc3, {30{8'h3c}}};
	tps_meas_type meas = '0;
	tps_ctrl_type ctrl;
	int           errors = 0;
	int           checked = 0;
	always #2.5 mclk = ~mclk;
	tps_host_model u_host (.i_mclk(mclk), .o_ptr_load(ld), .o_ptr_addr(pa),
		.o_wr(wr), .o_wdata(wd), .o_rd(rd), .i_rdata(rdat), .i_rvalid(rv));
	tps_reg_bank DUT (.i_mclk(mclk), .i_arst_n(arst_n), .i_ptr_load(ld),
		.i_ptr_addr(pa), .i_wr(wr), .i_wdata(wd), .i_rd(rd),
		.o_rdata(rdat), .o_rvalid(rv), .i_meas(meas), .i_motion_hit(hit),
		.i_nvm_image(nvm), .i_bus_address(8'h5a), .o_ctrl(ctrl),
		.o_int_n(int_n));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic go(input logic [2:0] k, input logic [7:0] d);
		u_host.op(k, d, v, q);
	endtask
	task automatic rdb(input logic [7:0] exp);
		go(3'h1, 8'h00);
		go(3'h0, 8'h00);
		chk({7'h00, v}, 8'h01);
		chk(q, exp);
	endtask
	task automatic pulse_live(input logic [7:0] c);
		@(negedge mclk) meas.live_condition = c;
		@(negedge mclk) meas.live_condition = 8'h00;
	endtask
	task automatic close_out;
		$display("checked %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole run is about 120 cycles; this allows over thirty times that
	initial begin
		#20000;
		errors++;
		close_out();
	end
	initial begin
		wb = '{8'ha5, 8'hff, 8'h11, 8'h22, 8'h33, 8'hff, 8'hff, 8'h44,
			8'hbe, 8'hef, 8'hff, 8'h80};
		rb = '{8'ha5, 8'h0f, 8'h11, 8'h22, 8'h33, 8'h1f, 8'h1f, 8'h44,
			8'hbe, 8'hef, 8'h00, 8'h80};
		repeat (16) @(negedge mclk);
		arst_n = 1'b1;
		go(3'h4, 8'h14);
		foreach (wb[i])
			go(3'h2, wb[i]);
		go(3'h4, 8'h14);
		foreach (rb[i])
			rdb(rb[i]);
		chk({ctrl.filter_b_select, ctrl.filter_a_select}, 8'ha5);
		chk({3'h0, ctrl.motion_cycle, ctrl.presence_source,
			ctrl.overtemp_dir}, 8'h1f);
		chk(ctrl.overtemp_limit[7:0], 8'hef);
		$display("test control done");
		@(negedge mclk);
		meas = '{17'h1abcd, 15'h3456, 20'h12345, 20'h6789a, 16'hbeef,
			8'h81, 8'h42, 8'h24, 8'h00};
		hit = 1'b1;
		@(negedge mclk) hit = 1'b0;
		ex = {meas.object_raw, meas.ambient_raw, meas.object_filter_a,
			meas.object_filter_b, meas.ambient_filter, meas.object_filter_b,
			4'h0, meas.presence_delta, meas.motion_delta, meas.ambient_jump};
		go(3'h4, 8'h01);
		for (int i = 0; i < 18; i++) begin
			go(i < 17 ? 3'h1 : 3'h0, 8'h00);
			if (i > 0)
				chk(q, ex[143-8*i -: 8]);
		end
		wrp = {8'h5a, 8'h00, ex[135:128], 8'h00};
		go(3'h4, 8'h3f);
		for (int i = 0; i < 4; i++) begin
			go(i < 3 ? 3'h1 : 3'h0, 8'h00);
			if (i > 0)
				chk(q, wrp[39-8*i -: 8]);
		end
		go(3'h4, 8'h3e);
		rdb(8'hc3);
		$display("test readback done");
		go(3'h4, 8'h13);
		go(3'h2, 8'hff);
		go(3'h4, 8'h0f);
		go(3'h2, 8'h00);
		go(3'h4, 8'h0f);
		rdb(8'h81);
		go(3'h4, 8'h1a);
		go(3'h2, 8'he4);
		go(3'h4, 8'h1a);
		rdb(8'h04);
		$display("test write guard done");
		pulse_live(8'h22);
		chk({7'h00, int_n}, 8'h00);
		go(3'h4, 8'h12);
		rdb(8'h22);
		@(negedge mclk);
		chk({7'h00, int_n}, 8'h01);
		go(3'h4, 8'h12);
		rdb(8'h00);
		go(3'h4, 8'h19);
		go(3'h2, 8'h00);
		// Drop the write strobe so it does not repeat during the pulse
		go(3'h0, 8'h00);
		pulse_live(8'h01);
		chk({7'h00, int_n}, 8'h01);
		go(3'h4, 8'h12);
		rdb(8'h01);
		$display("test interrupt done");
		@(negedge mclk) arst_n = 1'b0;
		@(negedge mclk) arst_n = 1'b1;
		chk({6'h00, int_n, rv}, 8'h02);
		chk(ctrl.presence_limit, 8'h00);
		rdb(8'h00);
		rdb(ex[135:128]);
		$display("test reset done");
		close_out();
	end
endmodule
`default_nettype wire
